/* dv/pin_env.sv */
// pin environment: outside drivers and pull-ups around the pin block
`timescale 1ns/10ps
`default_nettype none
module pin_env (
   // pin block side
   input wire logic [4:0] drv_i,
   input wire logic [4:0] drv_oe_i,
   input wire logic [3:0] od_oe_i,
   // outside sources
   input wire logic [4:0] ext_i,
   // resolved lines
   output logic [4:0] gpio_line_o,
   output logic [3:0] od_line_o
);
   // a released io line shows the outside source, never the last drive
   assign gpio_line_o = (drv_i & drv_oe_i) | (ext_i & ~drv_oe_i);
   // pull-ups hold released open-drain lines high
   assign od_line_o = ~od_oe_i;
endmodule : pin_env
`default_nettype wire

/* dv/tuner_pll_pin_functions_tb.sv */
// self-checking bench of the pin function block
`timescale 1ns/10ps
`default_nettype none
module tuner_pll_pin_functions_tb;
   import pin_fn_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hF, od, od_oe, od_line, ref_sel_o;
   logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'h1C;
   logic ack_o, phase_up_i = 1, phase_dn_i = 0, standby_o;
   logic pa, pa_oe, pb, pb_oe, m_a, m_b, m_p;
   logic [4:0] gpio_i, gpio_o, gpio_oe_o, ext = 5'h00, pins;
   logic [1:0] xtal_sel_o;
   int num_errors = 0, check_count = 0, cycles = 0, n;
   always #5 clk_i = ~clk_i;
   tuner_pll_pin_functions u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .open_drain_out_port_o(od), .open_drain_out_port_oe_o(od_oe),
      .gpio_i, .gpio_o, .gpio_oe_o, .phase_up_i, .phase_dn_i,
      .phase_err_out_a_o(pa), .phase_err_out_a_oe_o(pa_oe),
      .phase_err_out_b_o(pb), .phase_err_out_b_oe_o(pb_oe),
      .gp_meas_if_a_o(m_a), .gp_meas_if_b_o(m_b),
      .gp_meas_pilot_o(m_p), .xtal_sel_o, .ref_sel_o, .standby_o);
   pin_env u_env (.drv_i(gpio_o), .drv_oe_i(gpio_oe_o), .od_oe_i(od_oe),
      .ext_i(ext), .gpio_line_o(gpio_i), .od_line_o(od_line));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function automatic logic [31:0] reg2(logic [3:0] ot, logic [4:0] dir,
         logic ck, logic [2:0] ms);
      return {19'h0, ot, dir, ck, ms};
   endfunction : reg2
   // selected pin passes to its counter input, the others stay low
   function automatic logic [2:0] meas_exp(int s, logic [4:0] p);
      return {s == 2 && p[2], s == 1 && p[4], s == 0 && p[3]};
   endfunction : meas_exp
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (ack_o !== 1'b1) begin
         num_errors++;
         $display("wrong value ack exp 1 got %b", ack_o);
      end
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      we_i <= 0;
   endtask : wb
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      chk("od_oe", 0, od_oe);
      chk("od_line", 4'hF, od_line);
      chk("gpio_oe", 0, gpio_oe_o);
      chk("standby", 1, standby_o);
      chk("do_oe", 0, {pa_oe, pb_oe});
      wb(0, 4'h0, 0);
      chk("reg1", 32'h0000000F, rd);
      wb(0, 4'h4, 0);
      chk("reg2", 0, rd);
      for (int s = 0; s < 4; s++) begin
         wb(1, 4'h0, {26'h0, s[1:0], 4'h3});
         @(posedge clk_i);
         {phase_up_i, phase_dn_i} <= s[1:0];
         @(negedge clk_i);
         chk("xtal", s, xtal_sel_o);
         chk("standby", 0, standby_o);
         chk("do_oe", {2{s[1] ^ s[0]}}, {pa_oe, pb_oe});
         chk("do_val", {2{s[1]}}, {pa, pb});
      end
      wb(1, 4'h0, 32'h0000000F);
      @(posedge clk_i);
      {phase_up_i, phase_dn_i} <= 2'h2;
      @(negedge clk_i);
      chk("do_oe", 0, {pa_oe, pb_oe});
      for (n = 0; n < 8; n++) begin
         seed = xs(seed);
         @(posedge clk_i);
         ext <= seed[18:14];
         wb(1, 4'h4, reg2(seed[3:0], seed[8:4], 1'b0, 3'h0));
         wb(1, 4'hC, {27'h0, seed[13:9]});
         wb(0, 4'h4, 0);
         chk("reg2", reg2(seed[3:0], seed[8:4], 1'b0, 3'h0), rd);
         pins = (seed[13:9] & seed[8:4]) | (seed[18:14] & ~seed[8:4]);
         wb(0, 4'h8, 0);
         chk("status", {22'h0, 1'b1, 4'h0, pins}, rd);
         @(negedge clk_i);
         chk("od_oe", seed[3:0], od_oe);
         chk("od_o", 0, od);
         chk("gpio_oe", seed[8:4], gpio_oe_o);
      end
      for (int s = 0; s < 3; s++) begin
         seed = xs(seed);
         // one select bit per counter input
         wb(1, 4'h4, reg2(4'h0, 5'h00, 1'b0, 3'h1 << s));
         @(posedge clk_i);
         ext <= seed[4:0];
         @(negedge clk_i);
         chk("meas", meas_exp(s, seed[4:0]), {m_p, m_b, m_a});
         chk("meas_oe", 0, gpio_oe_o);
      end
      wb(1, 4'h4, reg2(4'h0, 5'h00, 1'b1, 3'h0));
      @(negedge clk_i);
      n = 0;
      // four-cycle clock: high on half of any 16 samples
      repeat (16) begin
         @(negedge clk_i);
         n += int'(gpio_i[0] === 1'b1);
      end
      chk("clk_high", 8, n);
      chk("clk_oe", 1, gpio_oe_o[0]);
      wb(1, 4'h4, reg2(4'h0, 5'h00, 1'b0, 3'h0));
      @(negedge clk_i);
      chk("clk_off", 0, {gpio_oe_o[0], gpio_o[0]});
      wb(1, 4'h6, 32'hFFFFFFFF);
      wb(0, 4'h6, 0);
      chk("unmapped", 0, rd);
      complete_run();
   end
endmodule : tuner_pll_pin_functions_tb
`default_nettype wire

/* src/pin_fn_map.svh */
// offsets, field positions, reset values and timing counts of the pin block
`ifndef PIN_FN_MAP_SVH
`define PIN_FN_MAP_SVH
// register byte offsets
`define OFF_IN_REG1   4'h0
`define OFF_IN_REG2   4'h4
`define OFF_PIN_STAT  4'h8
`define OFF_GPIO_OUT  4'hC
// input register 1 fields
`define F_REF_LSB     0
`define F_OSC_LSB     4
// input register 2 fields
`define F_MEAS_LSB    0
`define F_CLKOUT      3
`define F_GPIO_DIR_LSB 4
`define F_OT_LSB      16
// reset values
`define RST_IN_REG1   32'h0000000F
`define RST_IN_REG2   32'h00000000
`define RST_GPIO_OUT  32'h00000000
// reference selection value meaning standby
`define REF_STANDBY   4'hF
// system clock output divider: half period in clk_i cycles
`define SYSCLK_HALF   4'h2
`endif

/* src/pin_fn_pkg.sv */
// types shared by the pin function block
package pin_fn_pkg;
   typedef enum logic [1:0] {XTAL_3M6, XTAL_4M5, XTAL_7M2, XTAL_10M8} xtal_sel_t;
   typedef struct packed {
      logic [3:0] ref_sel;
      xtal_sel_t xtal;
   } in_reg1_t;
   typedef struct packed {
      logic [3:0] ot_off;
      logic [4:0] gpio_dir;
      logic clk_out_en;
      logic [2:0] meas_sel;
   } in_reg2_t;
   typedef struct packed {
      logic [4:0] o;
      logic [4:0] oe;
   } gpio_drive_t;
endpackage : pin_fn_pkg

/* src/sysclk_div.sv */
// divider that makes the system clock driven out of the first io pin
`timescale 1ns/10ps
`default_nettype none
`include "pin_fn_map.svh"
module sysclk_div (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   // divided clock
   output logic sysclk_o
);
   logic [3:0] cnt_q, cnt_d;
   logic clk_q, clk_d;

   always_comb begin
      cnt_d = cnt_q;
      clk_d = clk_q;
      if (!run_i) begin
         cnt_d = 4'h0;
         clk_d = 1'b0;
      end else if (cnt_q == `SYSCLK_HALF - 4'h1) begin
         cnt_d = 4'h0;
         clk_d = ~clk_q;
      end else begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
         clk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
      end
   end

   assign sysclk_o = clk_q;
endmodule : sysclk_div
`default_nettype wire

/* src/tuner_pll_pin_functions.sv */
// pin function and power-on state logic of the tuning pll device
// Notes on behaviour
// - reference and internal clock come from a crystal of a selectable frequency.
// - the serial port sets divisor, mode, counter and io control; here a bus stands in.
// - four open-drain output ports only pull low and start released.
// - the five cmos io ports each are input or output and start as inputs.
// - the first io pin can be switched to drive the system clock out.
// - the two if io pins can become counter frequency inputs; both start as ports.
// - the pilot io pin can become the counter period input; it starts as a port.
// - both phase comparator pins carry the same tri-state phase error.
// - one bit of input register 2 selects port or system clock on the first pin.
// - in standby both phase comparator pins float.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pin_fn_map.svh"
module tuner_pll_pin_functions
   import pin_fn_pkg::*;
#(
   parameter int N_GPIO = 5,
   parameter int N_OT = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // open-drain output ports
   output logic [N_OT-1:0] open_drain_out_port_o,
   output logic [N_OT-1:0] open_drain_out_port_oe_o,
   // cmos io ports, bit 0 first pin, 2 pilot, 3 and 4 the if pins
   input wire logic [N_GPIO-1:0] gpio_i,
   output logic [N_GPIO-1:0] gpio_o,
   output logic [N_GPIO-1:0] gpio_oe_o,
   // phase comparator
   input wire logic phase_up_i,
   input wire logic phase_dn_i,
   output logic phase_err_out_a_o,
   output logic phase_err_out_a_oe_o,
   output logic phase_err_out_b_o,
   output logic phase_err_out_b_oe_o,
   // to the counter and clock sections
   output logic gp_meas_if_a_o,
   output logic gp_meas_if_b_o,
   output logic gp_meas_pilot_o,
   output logic [1:0] xtal_sel_o,
   output logic [3:0] ref_sel_o,
   output logic standby_o
);
   in_reg1_t r1_q, r1_d;
   in_reg2_t r2_q, r2_d;
   logic [N_GPIO-1:0] gout_q, gout_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic [31:0] wmask;
   logic [31:0] r1_w, r2_w, go_w;
   logic standby;
   logic sysclk;
   logic [N_GPIO-1:0] port_mode;
   gpio_drive_t gdrv;

   // byte lane mask from sel
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{sel_i[b]}};
      end
   end

   // register writes merged per byte lane
   always_comb begin
      r1_w = ({26'h0, r1_q} & ~wmask) | (dat_i & wmask);
      r2_w = ({19'h0, r2_q} & ~wmask) | (dat_i & wmask);
      go_w = ({{(32-N_GPIO){1'b0}}, gout_q} & ~wmask) | (dat_i & wmask);
   end

   always_comb begin
      r1_d = r1_q;
      r2_d = r2_q;
      gout_d = gout_q;
      ack_d = 1'b0;
      rdat_d = rdat_q;
      if (cyc_i && stb_i && !ack_q) begin
         ack_d = 1'b1;
         rdat_d = 32'h0;
         case (adr_i)
            `OFF_IN_REG1: begin
               if (we_i) begin
                  r1_d.ref_sel = r1_w[`F_REF_LSB +: 4];
                  r1_d.xtal = xtal_sel_t'(r1_w[`F_OSC_LSB +: 2]);
               end
               rdat_d = {26'h0, r1_q.xtal, r1_q.ref_sel};
            end
            `OFF_IN_REG2: begin
               if (we_i) begin
                  r2_d = in_reg2_t'(r2_w[12:0]);
               end
               rdat_d = {19'h0, r2_q};
            end
            `OFF_GPIO_OUT: begin
               if (we_i) begin
                  gout_d = go_w[N_GPIO-1:0];
               end
               rdat_d = {{(32-N_GPIO){1'b0}}, gout_q};
            end
            `OFF_PIN_STAT: begin
               rdat_d = {22'h0, standby, 4'h0, gpio_i};
            end
            default: begin
               rdat_d = 32'h0;
            end
         endcase
      end
   end

   // power-on: standby, 3.6 mhz crystal, ports input, open drains off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // fields placed by their register positions, not struct order
         r1_q.ref_sel <= 4'(`RST_IN_REG1 >> `F_REF_LSB);
         r1_q.xtal <= xtal_sel_t'(2'(`RST_IN_REG1 >> `F_OSC_LSB));
         r2_q <= in_reg2_t'(13'(`RST_IN_REG2));
         gout_q <= '0;
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         r1_q <= r1_d;
         r2_q <= r2_d;
         gout_q <= gout_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdat_q;
   assign standby = (r1_q.ref_sel == `REF_STANDBY);
   assign standby_o = standby;
   assign ref_sel_o = r1_q.ref_sel;
   assign xtal_sel_o = r1_q.xtal;

   sysclk_div u_sysclk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(r2_q.clk_out_en),
      .sysclk_o(sysclk)
   );

   // a pin handed to a counter input no longer acts as a port
   always_comb begin
      port_mode = '1;
      port_mode[0] = ~r2_q.clk_out_en;
      port_mode[2] = ~r2_q.meas_sel[2];
      port_mode[3] = ~r2_q.meas_sel[0];
      port_mode[4] = ~r2_q.meas_sel[1];
   end

   generate
      for (genvar g = 0; g < N_GPIO; g++) begin : g_io
         always_comb begin
            gdrv.oe[g] = port_mode[g] & r2_q.gpio_dir[g];
            gdrv.o[g] = port_mode[g] & r2_q.gpio_dir[g] & gout_q[g];
         end
      end
      for (genvar k = 0; k < N_OT; k++) begin : g_ot
         // only ever pulls low, so data is held at zero
         assign open_drain_out_port_o[k] = 1'b0;
         assign open_drain_out_port_oe_o[k] = r2_q.ot_off[k];
      end
   endgenerate

   // clock out overrides the port drive on the first pin
   always_comb begin
      gpio_o = gdrv.o;
      gpio_oe_o = gdrv.oe;
      if (r2_q.clk_out_en) begin
         gpio_o[0] = sysclk;
         gpio_oe_o[0] = 1'b1;
      end
   end

   assign gp_meas_if_a_o = r2_q.meas_sel[0] & gpio_i[3];
   assign gp_meas_if_b_o = r2_q.meas_sel[1] & gpio_i[4];
   assign gp_meas_pilot_o = r2_q.meas_sel[2] & gpio_i[2];

   // both pins share one driver; level high on up, low on down
   always_comb begin
      phase_err_out_a_o = phase_up_i;
      phase_err_out_b_o = phase_up_i;
      phase_err_out_a_oe_o = ~standby & (phase_up_i ^ phase_dn_i);
      phase_err_out_b_oe_o = ~standby & (phase_up_i ^ phase_dn_i);
   end

   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held two cycles");
   a_po_standby: assert property (@(posedge clk_i)
      !rst_i && $past(rst_i) |-> standby && gpio_oe_o == '0)
      else $error("not standby with inputs after reset");
   a_ot_release: assert property (@(posedge clk_i)
      !rst_i && $past(rst_i) |-> open_drain_out_port_oe_o == '0)
      else $error("open drain driving after reset");
   a_ot_low: assert property (@(posedge clk_i) disable iff (rst_i)
      open_drain_out_port_o == '0) else $error("open drain high");
   a_pd_same: assert property (@(posedge clk_i) disable iff (rst_i)
      phase_err_out_a_o == phase_err_out_b_o &&
      phase_err_out_a_oe_o == phase_err_out_b_oe_o)
      else $error("phase pins differ");
   a_pd_float: assert property (@(posedge clk_i) disable iff (rst_i)
      standby |-> !phase_err_out_a_oe_o && !phase_err_out_b_oe_o)
      else $error("phase pin driven in standby");
   a_clk_out: assert property (@(posedge clk_i) disable iff (rst_i)
      r2_q.clk_out_en && $past(r2_q.clk_out_en, 8) |->
      gpio_oe_o[0] && gpio_o[0] != $past(gpio_o[0], 2))
      else $error("first pin not toggling clock");
   a_meas_float: assert property (@(posedge clk_i) disable iff (rst_i)
      r2_q.meas_sel[0] |-> !gpio_oe_o[3])
      else $error("if pin driven while measuring");
   a_pilot_float: assert property (@(posedge clk_i) disable iff (rst_i)
      r2_q.meas_sel[2] |-> !gpio_oe_o[2] ##0 gp_meas_pilot_o == gpio_i[2])
      else $error("pilot pin not routed");
   a_sel_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o && $past(we_i && adr_i == `OFF_IN_REG2 && sel_i[0]) |->
      r2_q.clk_out_en == $past(dat_i[`F_CLKOUT]))
      else $error("clock select bit not stored");
endmodule : tuner_pll_pin_functions
`default_nettype wire
